// ### scp_host.sv
// controller end: wishbone slave that sends 24-bit frames and captures readback
`include "scp_map.svh"
module scp_host #(
    parameter int HALF_CYC = `SCP_SCLK_HALF_CYC
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    scp_if.host              link
);
    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    scp_pkg::scp_state_e     st_q;
    logic [23:0]             frame_q;
    logic [15:0]             rdata_q;
    logic [4:0]              bit_q;
    logic [7:0]              div_q;
    logic                    sclk_q;
    logic                    sel_n_q;
    logic                    sdi_q;
    logic                    rst_n_q;
    logic                    ack_q;
    logic [31:0]             dat_q;
    logic [2:0]              rb_sync_q;
    logic                    rb_q;
    logic [3:0]              rst_cnt_q;
    // a readback change counts only once the last two sync stages agree
    wire                     rb_bit = (rb_sync_q[1] == rb_sync_q[2]) ? rb_sync_q[2] : rb_q;
    // converter reset pin stays low for a minimum time after our own reset ends
    wire                     rst_done = (rst_cnt_q == 4'(`SCP_RST_CYC));
    wire                     busy = (st_q != scp_pkg::SCP_IDLE);
    wire                     req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire                     go = req & wb_we_i & (wb_adr_i == `SCP_WB_CMD) & wb_sel_i[3]
                                  & wb_dat_i[`SCP_CMD_GO_BIT] & ~busy;
    wire                     div_end = (div_q == 8'(HALF_CYC - 1));
    wire [31:0]              rd_mux = (wb_adr_i == `SCP_WB_RDATA) ? {16'h0000, rdata_q} :
                                      (wb_adr_i == `SCP_WB_STATUS) ? {31'h0, busy} :
                                      (wb_adr_i == `SCP_WB_CMD) ? {8'h00, frame_q} : 32'h0;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            dat_q <= rd_mux;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ****************************************************************
    // frame engine; sclk is derived here so it is no second domain
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q    <= scp_pkg::SCP_IDLE;
            frame_q <= '0;
            rdata_q <= '0;
            bit_q   <= '0;
            div_q   <= '0;
            sclk_q  <= 1'b0;
            sel_n_q <= 1'b1;
            sdi_q   <= 1'b0;
            rst_n_q <= 1'b0;
            rb_sync_q <= '0;
            rb_q    <= 1'b0;
            rst_cnt_q <= '0;
        end else begin
            rb_sync_q <= {rb_sync_q[1:0], link.readback_out};
            rb_q    <= rb_bit;
            rst_cnt_q <= rst_done ? rst_cnt_q : rst_cnt_q + 4'h1;
            rst_n_q <= rst_done;
            div_q <= div_end ? 8'h00 : div_q + 8'h01;
            case (st_q)
                scp_pkg::SCP_IDLE: begin
                    if (go) begin
                        frame_q <= wb_dat_i[23:0];
                        st_q    <= scp_pkg::SCP_SETUP;
                        div_q   <= '0;
                    end
                end
                scp_pkg::SCP_SETUP: begin
                    if (div_end && rst_n_q) begin
                        sel_n_q <= 1'b0;
                        sdi_q   <= frame_q[23];
                        bit_q   <= '0;
                        st_q    <= scp_pkg::SCP_SHIFT;
                    end
                end
                scp_pkg::SCP_SHIFT: begin
                    if (div_end) begin
                        sclk_q <= ~sclk_q;
                        if (!sclk_q) begin
                            // rising edge: readback valid, sample settled copy
                            if (bit_q >= 5'd8) begin
                                rdata_q <= {rdata_q[14:0], rb_bit};
                            end
                        end else begin
                            frame_q <= {frame_q[22:0], 1'b0};
                            sdi_q   <= frame_q[22];
                            bit_q   <= bit_q + 5'h01;
                            if (bit_q == 5'(`SCP_FRAME_BITS - 1)) begin
                                st_q <= scp_pkg::SCP_HOLD;
                            end
                        end
                    end
                end
                scp_pkg::SCP_HOLD: begin
                    if (div_end) begin
                        sel_n_q <= 1'b1;
                        st_q    <= scp_pkg::SCP_IDLE;
                    end
                end
                default: st_q <= scp_pkg::SCP_IDLE;
            endcase
        end
    end

    assign link.sclk           = sclk_q;
    assign link.sel_n          = sel_n_q;
    assign link.serial_data_in = sdi_q;
    assign link.reset_n        = rst_n_q;
endmodule // scp_host

// ### scp_map.svh
// register offsets, field positions, reset values and timing constants of the serial config port
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define SCP_FRAME_BITS      24
`define SCP_ADDR_BITS       8
`define SCP_DATA_BITS       16
`define SCP_CNT_BITS        5

// ****************************************************************
// device register offsets
// ****************************************************************
`define SCP_REG_SWRST       8'h00
`define SCP_REG_READBACK    8'h01
`define SCP_REG_INTERLEAVE  8'h07
`define SCP_REG_RAMP        8'h0A
`define SCP_REG_PDN         8'h0F
`define SCP_REG_LFNS        8'h14
`define SCP_REG_FRAMECLK    8'h1C
`define SCP_REG_SEED_LO     8'h23
`define SCP_REG_SEED_HI     8'h24
`define SCP_NUM_REGS        9

// ****************************************************************
// fields and reset values
// ****************************************************************
`define SCP_SWRST_BIT       0
`define SCP_READOUT_BIT     0
`define SCP_UPPER_ADDR_BIT  4
`define SCP_REG_RESET       16'h0000

// ****************************************************************
// controller wishbone registers (byte addresses)
// ****************************************************************
`define SCP_WB_CMD          4'h0
`define SCP_WB_RDATA        4'h4
`define SCP_WB_STATUS       4'h8
`define SCP_CMD_GO_BIT      24
`define SCP_CMD_READ_BIT    25

// ****************************************************************
// timing
// ****************************************************************
`define SCP_CLK_PERIOD_NS   8
`define SCP_SCLK_MIN_NS     50
`define SCP_SCLK_HALF_CYC   ((`SCP_SCLK_MIN_NS / 2 + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)
`define SCP_RST_MIN_NS      50
`define SCP_RST_CYC         ((`SCP_RST_MIN_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)

`endif

// ### scp_pkg.sv
// types used by the controller end of the serial config port
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_IDLE  = 2'b00,
        SCP_SETUP = 2'b01,
        SCP_SHIFT = 2'b10,
        SCP_HOLD  = 2'b11
    } scp_state_e;
endpackage

// ### scp_if.sv
// serial link between the configuration controller and the converter port
interface scp_if;
    logic sel_n;
    logic sclk;
    logic serial_data_in;
    logic readback_out;
    logic readback_oe;
    logic reset_n;

    modport device (
        input  sel_n,
        input  sclk,
        input  serial_data_in,
        input  reset_n,
        output readback_out,
        output readback_oe
    );
    modport host (
        output sel_n,
        output sclk,
        output serial_data_in,
        output reset_n,
        input  readback_out,
        input  readback_oe
    );
endinterface

// ### scp_reg.sv
// one 16-bit configuration register with reset and write strobe
`include "scp_map.svh"
module scp_reg (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        we,
    input  wire logic [15:0] wdata,
    output logic      [15:0] q
);
    // asynchronous: sclk stands still outside frames, so a reset may see no edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= `SCP_REG_RESET;
        end else if (we) begin
            q <= wdata;
        end
    end
endmodule // scp_reg

// ### scp_device.sv
// converter end: serial shift-in of frames, register file, readback driver
// ****************************************************************
// Notes on behaviour
// - shift data on rising sclk while select low
// - every 24th rising edge writes the register
// - leftover bits below 24 are dropped
// - back-to-back frames in one select period
// - eight address bits, sixteen data, msb first
// - readback output tri-stated after any reset
// - readout enabled drives addressed register out
// - readout mode blocks writes except address 01h
// - register 01h never shown on readback
// - controller enables readout, then sends address
// - read data shifts out msb first, same frame
// - data bits of read frame are ignored
// - readback bit changes after falling sclk
// - controller samples readback on rising sclk
// - clearing readout restores writes, tri-states output
// - software reset bit restores defaults, self-clears
// - hardware reset low initialises all registers
// ****************************************************************
`include "scp_map.svh"
module scp_device (
    scp_if.device              link,
    output logic [15:0]        interleave_ctrl,
    output logic [15:0]        ramp_start_value,
    output logic [15:0]        power_down_ctrl,
    output logic [15:0]        low_freq_noise_ctrl,
    output logic [15:0]        frame_clock_pattern,
    output logic [15:0]        prbs_seed_low,
    output logic [15:0]        prbs_seed_high_invert
);
    // ****************************************************************
    // frame shifter (sclk domain; the chip runs only on the link clock)
    // ****************************************************************
    logic [`SCP_CNT_BITS-1:0]   cnt_q;
    logic [22:0]                sh_q;
    logic                       swrst_q;
    logic [15:0]                readback_q;
    logic [15:0]                regs [`SCP_NUM_REGS];
    wire                        clk = link.sclk;
    // resets act asynchronously, since sclk stands still outside frames
    wire                        rst = ~link.reset_n | swrst_q;
    wire                        last_bit = (cnt_q == 5'(`SCP_FRAME_BITS - 1));
    wire [23:0]                 frame = {sh_q, link.serial_data_in};
    wire [7:0]                  f_addr = frame[23:16];
    wire [15:0]                 f_data = frame[15:0];
    wire                        rd_mode = readback_q[`SCP_READOUT_BIT];
    wire                        wr_ok = ~rd_mode | (f_addr == `SCP_REG_READBACK);
    wire                        commit = ~link.sel_n & last_bit & wr_ok;

    // select high clears everything in flight; the frame is lost, not written
    always_ff @(posedge clk or posedge link.sel_n) begin
        if (link.sel_n) begin
            cnt_q <= '0;
            sh_q  <= '0;
        end else begin
            cnt_q <= last_bit ? '0 : cnt_q + 5'h01;
            sh_q  <= {sh_q[21:0], link.serial_data_in};
        end
    end

    // software reset clears itself when select rises, since sclk may not run again
    always_ff @(posedge clk or posedge link.sel_n) begin
        if (link.sel_n) begin
            swrst_q <= 1'b0;
        end else if (!link.reset_n || swrst_q) begin
            swrst_q <= 1'b0;
        end else begin
            swrst_q <= commit & (f_addr == `SCP_REG_SWRST) & f_data[`SCP_SWRST_BIT];
        end
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    localparam logic [7:0] ADDRS [`SCP_NUM_REGS] = '{`SCP_REG_SWRST, `SCP_REG_READBACK,
        `SCP_REG_INTERLEAVE, `SCP_REG_RAMP, `SCP_REG_PDN, `SCP_REG_LFNS,
        `SCP_REG_FRAMECLK, `SCP_REG_SEED_LO, `SCP_REG_SEED_HI};

    for (genvar i = 1; i < `SCP_NUM_REGS; i++) begin : g_reg
        scp_reg u_reg (
            .clk   (clk),
            .rst   (rst),
            .we    (commit & (f_addr == ADDRS[i])),
            .wdata (f_data),
            .q     (regs[i])
        );
    end
    assign regs[0] = '0;
    assign readback_q = regs[1];

    // ****************************************************************
    // readback: address known after bit 8, data out on falling edges
    // ****************************************************************
    logic [15:0]                out_sh_q;
    logic                       oe_q;
    logic [15:0]                sel_val;
    wire [7:0]                  a_now = {sh_q[6:0], link.serial_data_in};
    wire                        addr_done = ~link.sel_n & (cnt_q == 5'(`SCP_ADDR_BITS - 1));
    always_comb begin
        sel_val = '0;
        for (int i = 2; i < `SCP_NUM_REGS; i++) begin
            if (a_now == ADDRS[i]) begin
                sel_val = regs[i];
            end
        end
    end

    logic [15:0]                load_q;
    logic                       load_v_q;
    always_ff @(posedge clk) begin
        load_v_q <= addr_done & rd_mode;
        load_q   <= sel_val;
    end

    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            oe_q     <= 1'b0;
            out_sh_q <= '0;
        end else if (load_v_q) begin
            out_sh_q <= load_q;
            oe_q     <= 1'b1;
        end else begin
            out_sh_q <= {out_sh_q[14:0], 1'b0};
            oe_q     <= rd_mode;
        end
    end
    assign link.readback_out = out_sh_q[15];
    assign link.readback_oe  = oe_q & rd_mode;

    assign interleave_ctrl       = regs[2];
    assign ramp_start_value      = regs[3];
    assign power_down_ctrl       = regs[4];
    assign low_freq_noise_ctrl   = regs[5];
    assign frame_clock_pattern   = regs[6];
    assign prbs_seed_low         = regs[7];
    assign prbs_seed_high_invert = regs[8];
endmodule // scp_device

// ### scp_link_sva.sv
// concurrent checks on the serial link between the controller and converter ends
`include "scp_map.svh"
module scp_link_sva (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic readback_out,
    input wire logic readback_oe,
    input wire logic reset_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // ****************************************************************
    // rising serial clock edges seen in the current select period
    // ****************************************************************
    logic       sclk_q;
    logic [4:0] rise_q;
    logic [4:0] rise_d;

    assign rise_d = sel_n ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};

    always_ff @(posedge clock) begin
        sclk_q <= sclk;
        rise_q <= nrst ? rise_d : 5'h00;
    end

    // cycles the converter reset pin has been low since our own reset ended
    logic [3:0] low_q;
    always_ff @(posedge clock) begin
        if (!nrst || reset_n) begin
            low_q <= 4'h0;
        end else if (low_q != 4'hF) begin
            low_q <= low_q + 4'h1;
        end
    end

    sequence high_phase;
        sclk [*4];
    endsequence
    sequence low_phase;
        !sclk [*4];
    endsequence

    chk_frame_24_edges: assert property ($rose(sel_n) |-> rise_q == 5'h18)
        else $error("select period did not hold exactly one whole frame");
    chk_sclk_idle_low: assert property (sel_n |-> !sclk)
        else $error("serial clock moved outside a select period");
    chk_data_stable_high: assert property ((!sel_n && sclk) |-> $stable(serial_data_in))
        else $error("serial data changed while serial clock high");
    chk_high_time_min: assert property ($rose(sclk) |-> high_phase)
        else $error("serial clock high phase too short");
    chk_low_time_min: assert property (($fell(sclk) && !sel_n) |-> low_phase)
        else $error("serial clock low phase too short");
    chk_select_setup_time: assert property ($fell(sel_n) |-> low_phase)
        else $error("serial clock rose too soon after select fell");
    chk_dout_after_fall: assert property
        ((readback_oe && $stable(readback_oe) && $changed(readback_out)) |-> !sclk)
        else $error("readback bit changed while serial clock high");
    chk_reset_link_idle: assert property
        (@(posedge clock) disable iff (1'b0) !nrst |=> (sel_n && !sclk))
        else $error("link not idle during reset");
    chk_reset_pulse_width: assert property ($rose(reset_n) |-> low_q >= 4'(`SCP_RST_CYC))
        else $error("converter reset pulse too short");

    cover property ($rose(readback_oe));
endmodule // scp_link_sva

// ### tb.sv
// testbench: wishbone-driven controller end talking to the converter end
`include "scp_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock;
    logic        nrst;
    logic [3:0]  wb_adr;
    logic [31:0] wb_dat_w;
    logic        wb_we;
    logic        wb_cyc;
    logic        wb_stb;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic [15:0] dev_out [7];
    logic [31:0] rd;
    int          bad_count;
    int          n_checks;
    int          cycles;
    localparam logic [7:0] addr_tab [7] = '{`SCP_REG_INTERLEAVE, `SCP_REG_RAMP, `SCP_REG_PDN,
        `SCP_REG_LFNS, `SCP_REG_FRAMECLK, `SCP_REG_SEED_LO, `SCP_REG_SEED_HI};
    localparam logic [15:0] val_tab [7] = '{16'h0003, 16'hA5C3, 16'h0755, 16'h00AA,
        16'h4ABC, 16'h1234, 16'hFE55};

    scp_if scp_if_i ();
    scp_host #(.HALF_CYC(4)) scp_host_i (.clock(clock), .nrst(nrst), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat_w), .wb_we_i(wb_we), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(scp_if_i));
    scp_device scp_device_i (.link(scp_if_i), .interleave_ctrl(dev_out[0]),
        .ramp_start_value(dev_out[1]), .power_down_ctrl(dev_out[2]),
        .low_freq_noise_ctrl(dev_out[3]), .frame_clock_pattern(dev_out[4]),
        .prbs_seed_low(dev_out[5]), .prbs_seed_high_invert(dev_out[6]));
    scp_link_sva scp_link_sva_i (.clock(clock), .nrst(nrst), .sel_n(scp_if_i.sel_n),
        .sclk(scp_if_i.sclk), .serial_data_in(scp_if_i.serial_data_in),
        .readback_out(scp_if_i.readback_out), .readback_oe(scp_if_i.readback_oe),
        .reset_n(scp_if_i.reset_n));

    // ****************************************************************
    // clock, timeout and shared tasks
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // a whole run needs about 4000 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // the request stands until the edge that samples ack; data is taken and released there
    task automatic wb_cycle(input logic [3:0] a, input logic [31:0] d, input logic w);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_we <= w;
        do begin
            @(posedge clock);
        end while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock);
    endtask

    // one frame, then wait for busy to clear and fetch the captured readback
    task automatic send(input logic rdf, input logic [7:0] a, input logic [15:0] d);
        wb_cycle(`SCP_WB_CMD, {6'h00, rdf, 1'b1, a, d}, 1'b1);
        do begin
            wb_cycle(`SCP_WB_STATUS, 32'h0, 1'b0);
        end while (rd[0] !== 1'b0);
        wb_cycle(`SCP_WB_RDATA, 32'h0, 1'b0);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        nrst <= 1'b0;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_adr <= 4'h0;
        wb_dat_w <= 32'h0;
        cycles <= 0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        send(1'b0, `SCP_REG_SWRST, 16'h0001);
        for (int i = 0; i < 7; i++) check(dev_out[i], 16'h0000);
        check(scp_if_i.readback_oe, 1'b0);
        end_test("soft reset");
        for (int i = 0; i < 7; i++) send(1'b0, addr_tab[i], val_tab[i]);
        for (int i = 0; i < 7; i++) check(dev_out[i], val_tab[i]);
        wb_cycle(4'hC, 32'h0, 1'b0);
        check(rd, 32'h0);
        end_test("writes");
        send(1'b0, `SCP_REG_READBACK, 16'h0001);
        check(scp_if_i.readback_oe, 1'b1);
        // data bits of a read frame are junk on purpose
        send(1'b1, `SCP_REG_PDN, 16'hFFFF);
        check(rd[15:0], val_tab[2]);
        check(dev_out[2], val_tab[2]);
        send(1'b0, `SCP_REG_SEED_LO, 16'h0000);
        check(dev_out[5], val_tab[5]);
        send(1'b1, `SCP_REG_SEED_LO, 16'h0000);
        check(rd[15:0], val_tab[5]);
        send(1'b1, `SCP_REG_READBACK, 16'h0001);
        check(rd[15:0], 16'h0000);
        send(1'b0, `SCP_REG_READBACK, 16'h0000);
        check(scp_if_i.readback_oe, 1'b0);
        send(1'b0, `SCP_REG_SEED_LO, 16'h0000);
        check(dev_out[5], 16'h0000);
        end_test("readback");
        send(1'b0, `SCP_REG_SWRST, 16'h0001);
        for (int i = 0; i < 7; i++) check(dev_out[i], 16'h0000);
        end_test("soft reset again");
        send(1'b0, `SCP_REG_PDN, val_tab[2]);
        check(dev_out[2], val_tab[2]);
        nrst <= 1'b0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        check(dev_out[2], 16'h0000);
        check(scp_if_i.readback_oe, 1'b0);
        send(1'b0, `SCP_REG_PDN, val_tab[2]);
        check(dev_out[2], val_tab[2]);
        end_test("hardware reset");
        stop_test();
    end
endmodule // tb
